// [logic/hsw_pkg.sv]
// Constants and types shared by the operating-mode controller
//
// Summary of operation
// - Wake is the OR of the four input-on levels and the reset-wake pin.
// - Fail is the OR of a serial failure and the limp-home level.
// - After supply-up, rest in sleep with channels off until wake rises.
// - Normal mode holds while awake with no fail condition.
// - Normal: channels 1-4 follow on bit or enabled direct input; 5-6 on bit.
// - A rising channel control starts the overcurrent window of outputs 1-5.
// - Enter fail mode immediately on limp-home high or serial failure.
// - Fail: outputs 1-4 follow direct inputs, 5-6 off, no PWM, writes ignored except readback select.
// - Fail with diagnosis: reads return the status chosen by readback select.
// - Fail mode forces the maximum overcurrent profile.
// - Fail: overload or undervoltage on outputs 1-4 uses automatic restart.
// - Fail: overtemperature, high stage or severe short latch the output off.
// - Fail: windows timed from input-on levels, channels follow direct inputs.
// - Each wake-up clears all serial registers and blanks faults for a while.
// - Initialisation completes 50 us after wake-up.
// - Normal to fail clears serial settings but keeps status registers.
// - Diagnosis stays in fail mode except when a serial line is stuck.
// - Fail to normal needs cause removed and toggle 0 then 1 within watchdog.
// - Fail to normal clears registers then sets status and cleared flags.
// - Register-cleared flag holds until quick status register 1 is read.
// - Supplies below power-on threshold give power-off with no logic active.
// - Toggle bit must flip every write; missing toggle in time is a failure.
// - Reset-wake pin low holds serial registers, flags and overload status in reset.
package hsw_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int INIT_TIME_US  = 50;
  localparam int INIT_CYC      = INIT_TIME_US * CLK_MHZ;
  localparam int BLANK_TIME_US = 10;
  localparam int BLANK_CYC     = BLANK_TIME_US * CLK_MHZ;
  localparam int WD_TIME_US    = 200;
  localparam int WD_CYC        = WD_TIME_US * CLK_MHZ;
  // ----------------------------------------
  // Register indices and fields
  // ----------------------------------------
  localparam int         NREG       = 15;
  localparam logic [3:0] IDX_INIT1  = 4'h0;
  localparam int         IDX_CH1    = 2;
  localparam logic [3:0] IDX_OUTCTL = 4'h8;
  localparam int         IDX_INEN   = 11;
  localparam int         STS_SEL    = 4;
  localparam logic [4:0] ADDR_STS1  = 5'h11;
  localparam int         ON_BIT     = 8;
  localparam int         STS_OVL    = 0;
  localparam int         STS_LAT    = 1;
  localparam int         STS_RCF    = 9;
  localparam int         STS_DSF    = 10;
  localparam logic [3:0] STS_FIRST  = 4'h1;
  localparam logic [3:0] STS_LASTCH = 4'h4;
  localparam logic [3:0] STS_LAST   = 4'h7;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {M_OFF, M_SLEEP, M_NORMAL, M_FAIL} hsw_mode_t;
  typedef struct packed {
    logic        tog;
    logic [10:0] data;
  } hsw_cmd_t;
endpackage

// [logic/hsw_sync.sv]
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module hsw_sync #(
  parameter int W = 1
)(
  // Clock, reset, enable
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         en_in,
  // Levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else if (en_in)
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// [logic/hsw_timer.sv]
// Reloadable down-counter with busy level and expiry pulse
`timescale 1ns/1ns
`default_nettype none
module hsw_timer #(
  parameter int N = 16
)(
  // Clock, reset, enable
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic en_in,
  // Control and status
  input  wire logic start_in,
  output logic      busy_out,
  output logic      expire_out
);
  localparam int CW = $clog2(N + 1);
  logic [CW-1:0] cnt;

  // Load on start, count down to zero
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cnt <= '0;
    else if (en_in)
    begin
      if (start_in)
        cnt <= CW'(N);
      else if (cnt != '0)
        cnt <= cnt - 1'b1;
    end
  end

  assign busy_out   = (cnt != '0);
  assign expire_out = en_in && !start_in && (cnt == CW'(1));
endmodule
`default_nettype wire

// [logic/hsw_mode_ctrl.sv]
// Operating-mode and fail-safe controller of a six-channel high-side switch
`timescale 1ns/1ns
`default_nettype none
module hsw_mode_ctrl #(
  parameter int INIT_CYC = hsw_pkg::INIT_CYC,
  parameter int WD_CYC   = hsw_pkg::WD_CYC
)(
  // Clock, reset, enable
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  input  wire logic              clk_en_in,
  // Pins from the controller and supplies
  input  wire logic [3:0]        direct_control_inputs_in,
  input  wire logic              limp_home_in,
  input  wire logic              reset_wake_pin_in,
  input  wire logic              supply_ok_in,
  // Serial front-end status
  input  wire logic              serial_count_err_in,
  input  wire logic              serial_stuck_in,
  // Power stage events
  input  wire logic [3:0]        overload_in,
  input  wire logic [3:0]        severe_fault_in,
  // Register port
  input  wire logic [4:0]        addr_in,
  input  wire logic [15:0]       wr_data_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [15:0]       rd_data_out,
  // Channel and mode outputs
  output logic      [5:0]        channel_control_signal_out,
  output logic      [4:0]        oc_window_start_out,
  output logic                   oc_profile_max_out,
  output logic                   fault_blank_out,
  output logic                   init_done_out,
  output logic                   diag_avail_out,
  output hsw_pkg::hsw_mode_t     mode_out
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  localparam int SW = 15;
  logic [SW-1:0] raw_pins;
  logic [SW-1:0] sync_pins;
  logic [3:0]    in_s;
  logic [3:0]    ovl_s;
  logic [3:0]    sev_s;
  logic          limp_s;
  logic          reset_wake_pin_s;
  logic          supply_s;

  // All pins pass two flops before use
  assign raw_pins = {supply_ok_in, reset_wake_pin_in, limp_home_in,
                     severe_fault_in, overload_in, direct_control_inputs_in};
  hsw_sync #(.W(SW)) u_sync (
    .clk_in  (ref_clk_in),
    .nrst_in (nrst_in),
    .en_in   (clk_en_in),
    .d_in    (raw_pins),
    .q_out   (sync_pins)
  );
  assign in_s     = sync_pins[3:0];
  assign ovl_s    = sync_pins[7:4];
  assign sev_s    = sync_pins[11:8];
  assign limp_s   = sync_pins[12];
  assign reset_wake_pin_s   = sync_pins[13];
  assign supply_s = sync_pins[14];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  hsw_pkg::hsw_mode_t mode;
  hsw_pkg::hsw_mode_t next_mode;
  hsw_pkg::hsw_cmd_t  cmd;
  logic [10:0] set_reg [0:hsw_pkg::NREG-1];
  logic [5:0]  on_bits;
  logic [3:0]  inen;
  logic [3:0]  sel;
  logic [3:0]  latched;
  logic [3:0]  ovl_seen;
  logic [3:0]  in_q;
  logic [5:0]  next_chan;
  logic        wake;
  logic        fail_cond;
  logic        spi_fail;
  logic        diag_ok;
  logic        last_tog;
  logic        rec_stage;
  logic        device_status_flag;
  logic        register_cleared_flag;
  logic        por;
  logic        to_fail;
  logic        recover;
  logic        rec_arm;
  logic        wr_act;
  logic        tog_err;
  logic        set_we;
  logic        sel_we;
  logic        set_clr;
  logic        rd_sts1;
  logic        wd_start;
  logic        wd_busy;
  logic        wd_exp;
  logic        init_busy;
  logic        blank;

  // ----------------------------------------
  // Wake, fail and command decode
  // ----------------------------------------
  assign wake      = (|in_s) | reset_wake_pin_s;
  assign fail_cond = limp_s | spi_fail;
  assign cmd       = hsw_pkg::hsw_cmd_t'(wr_data_in[11:0]);
  // Writes reach settings other than the readback select only in normal mode with the pin high
  assign wr_act  = wr_in && reset_wake_pin_s && !addr_in[4] && (mode == hsw_pkg::M_NORMAL);
  assign tog_err = wr_act && (cmd.tog == last_tog);
  assign set_we  = wr_act && !tog_err;
  // Readback select stays writable in fail mode
  assign sel_we  = wr_in && reset_wake_pin_s && (mode == hsw_pkg::M_FAIL) && (addr_in == 5'h00);
  // Recovery handshake: toggle 0 then 1 inside one watchdog period
  assign rec_arm = (mode == hsw_pkg::M_FAIL) && !limp_s && wr_in && reset_wake_pin_s && !cmd.tog;
  assign recover = (mode == hsw_pkg::M_FAIL) && !limp_s && wr_in && reset_wake_pin_s
                   && cmd.tog && rec_stage && wd_busy;

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always_comb
  begin
    next_mode = mode;
    case (mode)
      hsw_pkg::M_OFF:    next_mode = hsw_pkg::M_SLEEP;
      // Sleep until wake rises
      hsw_pkg::M_SLEEP:  if (wake) next_mode = fail_cond ? hsw_pkg::M_FAIL : hsw_pkg::M_NORMAL;
      // Fail entry without delay
      hsw_pkg::M_NORMAL: if (fail_cond) next_mode = hsw_pkg::M_FAIL;
      hsw_pkg::M_FAIL:   if (recover) next_mode = hsw_pkg::M_NORMAL;
      default:           next_mode = hsw_pkg::M_OFF;
    endcase
    // Supply loss and loss of wake override all
    if (!supply_s)
      next_mode = hsw_pkg::M_OFF;
    else if (!wake && mode != hsw_pkg::M_OFF)
      next_mode = hsw_pkg::M_SLEEP;
  end

  // Mode register
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mode <= hsw_pkg::M_OFF;
    else if (clk_en_in)
      mode <= next_mode;
  end

  assign por     = (mode == hsw_pkg::M_SLEEP) && ((next_mode == hsw_pkg::M_NORMAL)
                   || (next_mode == hsw_pkg::M_FAIL));
  assign to_fail = (mode == hsw_pkg::M_NORMAL) && (next_mode == hsw_pkg::M_FAIL);
  // Settings clear on wake, pin low, fail entry and recovery
  assign set_clr = por || !reset_wake_pin_s || to_fail || recover;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  assign wd_start = por || set_we || rec_arm || recover;
  hsw_timer #(.N(WD_CYC)) u_wd (
    .clk_in     (ref_clk_in),
    .nrst_in    (nrst_in),
    .en_in      (clk_en_in),
    .start_in   (wd_start),
    .busy_out   (wd_busy),
    .expire_out (wd_exp)
  );
  hsw_timer #(.N(INIT_CYC)) u_init (
    .clk_in     (ref_clk_in),
    .nrst_in    (nrst_in),
    .en_in      (clk_en_in),
    .start_in   (por),
    .busy_out   (init_busy),
    .expire_out ()
  );
  hsw_timer #(.N(hsw_pkg::BLANK_CYC)) u_blank (
    .clk_in     (ref_clk_in),
    .nrst_in    (nrst_in),
    .en_in      (clk_en_in),
    .start_in   (por),
    .busy_out   (blank),
    .expire_out ()
  );

  // ----------------------------------------
  // Serial failure and handshake state
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      spi_fail <= 1'b0;
      diag_ok  <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (mode == hsw_pkg::M_SLEEP || mode == hsw_pkg::M_OFF || recover)
      begin
        spi_fail <= 1'b0;
        diag_ok  <= 1'b1;
      end
      else if (mode == hsw_pkg::M_NORMAL)
      begin
        if (tog_err || wd_exp || serial_count_err_in || serial_stuck_in)
          spi_fail <= 1'b1;
        if (serial_stuck_in)
          diag_ok <= 1'b0;
      end
    end
  end

  // Toggle bit history and first handshake step
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      last_tog  <= 1'b1;
      rec_stage <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (por || recover)
        last_tog <= 1'b1;
      else if (set_we)
        last_tog <= cmd.tog;
      if (mode != hsw_pkg::M_FAIL || recover || wd_exp)
        rec_stage <= 1'b0;
      else if (rec_arm)
        rec_stage <= 1'b1;
    end
  end

  // ----------------------------------------
  // Settings registers, one process per entry
  // ----------------------------------------
  for (genvar r = 0; r < hsw_pkg::NREG; r++)
  begin : g_set
    localparam bit OM = (r >= hsw_pkg::IDX_CH1) && (r < hsw_pkg::IDX_CH1 + 6);
    localparam int OB = OM ? r - hsw_pkg::IDX_CH1 : 0;
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
        set_reg[r] <= 11'h000;
      else if (clk_en_in)
      begin
        if (set_clr)
          set_reg[r] <= 11'h000;
        else if (set_we && addr_in[3:0] == 4'(r))
          set_reg[r] <= cmd.data;
        else if (OM && set_we && addr_in[3:0] == hsw_pkg::IDX_OUTCTL)
          set_reg[r][hsw_pkg::ON_BIT] <= cmd.data[OB];
        else if (r == 0 && sel_we)
          set_reg[r][3:0] <= cmd.data[3:0];
      end
    end
    if (OM)
    begin : g_on
      assign on_bits[OB] = set_reg[r][hsw_pkg::ON_BIT];
    end
  end
  assign sel = set_reg[0][hsw_pkg::STS_SEL-1:0];

  // ----------------------------------------
  // Per-channel fault state
  // ----------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_ch
    assign inen[i] = set_reg[hsw_pkg::IDX_INEN][2*i];
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        latched[i]  <= 1'b0;
        ovl_seen[i] <= 1'b0;
      end
      else if (clk_en_in)
      begin
        // Latch-off cleared only at wake-up
        if (por)
          latched[i] <= 1'b0;
        else if (mode == hsw_pkg::M_FAIL && sev_s[i] && !blank)
          latched[i] <= 1'b1;
        if (por || !reset_wake_pin_s || recover)
          ovl_seen[i] <= 1'b0;
        else if (!blank && (ovl_s[i] || sev_s[i]))
          ovl_seen[i] <= 1'b1;
      end
    end
  end

  // Device and register-cleared flags; recovery set wins over read clear
  assign rd_sts1 = rd_in && reset_wake_pin_s && (((mode == hsw_pkg::M_NORMAL) && addr_in == hsw_pkg::ADDR_STS1)
                   || ((mode == hsw_pkg::M_FAIL) && diag_ok && sel == hsw_pkg::STS_FIRST));
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      device_status_flag <= 1'b0;
      register_cleared_flag <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (recover)
      begin
        device_status_flag <= 1'b1;
        register_cleared_flag <= 1'b1;
      end
      else if (por || !reset_wake_pin_s)
      begin
        device_status_flag <= 1'b0;
        register_cleared_flag <= 1'b0;
      end
      else if (rd_sts1)
        register_cleared_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Channel control
  // ----------------------------------------
  always_comb
  begin
    next_chan = 6'h00;
    if (mode == hsw_pkg::M_NORMAL)
      next_chan = {on_bits[5:4], on_bits[3:0] | (inen & in_s)};
    else if (mode == hsw_pkg::M_FAIL)
      next_chan = {2'b00, in_s & ~latched & ~ovl_s};
  end

  // Status word for readback
  function automatic logic [15:0] sts_word(input logic [3:0] k);
    logic [15:0] w;
    w = 16'h0000;
    if (k >= hsw_pkg::STS_FIRST && k <= hsw_pkg::STS_LAST)
      w[hsw_pkg::STS_DSF] = device_status_flag;
    if (k == hsw_pkg::STS_FIRST)
      w[hsw_pkg::STS_RCF] = register_cleared_flag;
    if (k >= hsw_pkg::STS_FIRST && k <= hsw_pkg::STS_LASTCH)
    begin
      w[hsw_pkg::STS_OVL] = ovl_seen[2'(k - 4'h1)];
      w[hsw_pkg::STS_LAT] = latched[2'(k - 4'h1)];
    end
    return w;
  endfunction

  // Registered outputs
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      channel_control_signal_out <= 6'h00;
      oc_window_start_out        <= 5'h00;
      oc_profile_max_out         <= 1'b0;
      init_done_out              <= 1'b0;
      diag_avail_out             <= 1'b0;
      in_q                       <= 4'h0;
    end
    else if (clk_en_in)
    begin
      channel_control_signal_out <= next_chan;
      in_q                       <= in_s;
      oc_window_start_out        <= 5'h00;
      if (mode == hsw_pkg::M_NORMAL)
        oc_window_start_out <= next_chan[4:0] & ~channel_control_signal_out[4:0];
      else if (mode == hsw_pkg::M_FAIL)
        oc_window_start_out <= {1'b0, in_s & ~in_q};
      oc_profile_max_out <= (next_mode == hsw_pkg::M_FAIL);
      init_done_out      <= (mode == hsw_pkg::M_NORMAL || mode == hsw_pkg::M_FAIL)
                            && !init_busy && !por;
      diag_avail_out     <= (next_mode == hsw_pkg::M_FAIL) && diag_ok;
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rd_data_out <= 16'h0000;
    else if (clk_en_in)
    begin
      rd_data_out <= 16'h0000;
      if (rd_in && reset_wake_pin_s)
      begin
        if (mode == hsw_pkg::M_FAIL)
        begin
          if (diag_ok)
            rd_data_out <= sts_word(sel);
        end
        else if (mode == hsw_pkg::M_NORMAL)
        begin
          if (addr_in[4])
            rd_data_out <= sts_word(addr_in[3:0]);
          else if (addr_in[3:0] != 4'hF)
            rd_data_out <= {5'h00, set_reg[addr_in[3:0]]};
        end
      end
    end
  end

  assign fault_blank_out = blank;
  assign mode_out        = mode;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_sleep_off;
    clk_en_in && mode == hsw_pkg::M_SLEEP |=> channel_control_signal_out == 6'h00;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("channels on in sleep");

  property p_normal_entry;
    clk_en_in && mode == hsw_pkg::M_SLEEP && supply_s && wake && !fail_cond
      |=> mode == hsw_pkg::M_NORMAL;
  endproperty
  a_normal_entry: assert property (p_normal_entry) else $error("no normal entry");

  property p_fail_entry;
    clk_en_in && mode == hsw_pkg::M_NORMAL && supply_s && wake && fail_cond
      |=> mode == hsw_pkg::M_FAIL;
  endproperty
  a_fail_entry: assert property (p_fail_entry) else $error("fail entry late");

  property p_fail_56_off;
    clk_en_in && mode == hsw_pkg::M_FAIL |=> channel_control_signal_out[5:4] == 2'b00;
  endproperty
  a_fail_56_off: assert property (p_fail_56_off) else $error("ch5/6 on in fail");

  property p_fail_clear;
    clk_en_in && to_fail |=> on_bits == 6'h00 && inen == 4'h0;
  endproperty
  a_fail_clear: assert property (p_fail_clear) else $error("settings kept");

  property p_recover_flags;
    clk_en_in && recover |=> device_status_flag && register_cleared_flag && mode == hsw_pkg::M_NORMAL && on_bits == 6'h00;
  endproperty
  a_recover_flags: assert property (p_recover_flags) else $error("flags not set");

  property p_rcf_read;
    clk_en_in && rd_sts1 && !recover && !por |=> !register_cleared_flag;
  endproperty
  a_rcf_read: assert property (p_rcf_read) else $error("rcf not cleared");

  property p_tog_err;
    clk_en_in && tog_err |=> spi_fail ##1 1'b1;
  endproperty
  a_tog_err: assert property (p_tog_err) else $error("toggle error missed");

  property p_latch_hold;
    latched[0] && !(clk_en_in && por) |=> latched[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

  property p_por_blank;
    clk_en_in && por |=> fault_blank_out && !init_done_out && on_bits == 6'h00;
  endproperty
  a_por_blank: assert property (p_por_blank) else $error("wake reset missing");

  property p_pin_low;
    clk_en_in && !reset_wake_pin_s && !recover |=> !register_cleared_flag && !device_status_flag && ovl_seen == 4'h0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("registers not held");

  c_normal: cover property (mode == hsw_pkg::M_SLEEP ##1 mode == hsw_pkg::M_NORMAL);
  c_fail:   cover property (mode == hsw_pkg::M_NORMAL ##1 mode == hsw_pkg::M_FAIL);
  c_recov:  cover property (recover ##1 mode == hsw_pkg::M_NORMAL);
endmodule
`default_nettype wire

// [testbench/hsw_mcu_model.sv]
// Microcontroller model: register port master and pin driver
`timescale 1ns/1ns
`default_nettype none
module hsw_mcu_model (
  // Clock and read data
  input  wire logic        clk_in,
  input  wire logic [15:0] rd_data_in,
  // Register port
  output logic      [4:0]  addr_out,
  output logic      [15:0] wr_data_out,
  output logic             wr_out,
  output logic             rd_out,
  // Pins
  output logic      [3:0]  din_out,
  output logic             limp_out,
  output logic             rwake_out
);
  logic tog = 1'b0;
  // Idle bus, pins low so the device sleeps
  initial
    {addr_out, wr_data_out, wr_out, rd_out, din_out, limp_out, rwake_out} = '0;
  // Pin levels; reset-wake goes low to high for a wake event
  task automatic pins(input logic [3:0] d, input logic l, input logic w);
    @(posedge clk_in);
    {din_out, limp_out, rwake_out} <= {d, l, w};
  endtask
  // One write; bad repeats the previous toggle bit
  task automatic wr(input logic [4:0] a, input logic [10:0] d, input logic bad);
    @(posedge clk_in);
    {addr_out, wr_data_out, wr_out} <= {a, 4'h0, tog ^ bad, d, 1'b1};
    @(posedge clk_in);
    wr_out <= 1'b0;
    tog = tog ^ ~bad;
  endtask
  // One read, data taken in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    {addr_out, rd_out} <= {a, 1'b1};
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rd_data_in;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench of the operating-mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, nrst, sup, stuck, cerr, cen;
  logic [3:0] ovl, sev, din;
  logic [4:0] addr, ows;
  logic [15:0] wd, rdd, v;
  logic wr, rd, limp, rwake, ocmax, blank, idone, diag;
  logic [5:0] ch;
  logic [16:0] r;
  hsw_pkg::hsw_mode_t mode;
  int fails, tests_run, cyc;
  // Device under test with shortened init and watchdog counts
  hsw_mode_ctrl #(.INIT_CYC(20), .WD_CYC(400)) DUT (.ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(cen),
    .direct_control_inputs_in(din), .limp_home_in(limp), .reset_wake_pin_in(rwake), .supply_ok_in(sup),
    .serial_count_err_in(cerr), .serial_stuck_in(stuck), .overload_in(ovl), .severe_fault_in(sev),
    .addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_data_out(rdd),
    .channel_control_signal_out(ch), .oc_window_start_out(ows), .oc_profile_max_out(ocmax),
    .fault_blank_out(blank), .init_done_out(idone), .diag_avail_out(diag), .mode_out(mode));
  // Far-side controller
  hsw_mcu_model u_mcu (.clk_in(clk), .rd_data_in(rdd), .addr_out(addr), .wr_data_out(wd), .wr_out(wr),
    .rd_out(rd), .din_out(din), .limp_out(limp), .rwake_out(rwake));
  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bounded wait for a mode
  task automatic wait_mode(input hsw_pkg::hsw_mode_t m);
    for (int n = 0; n < 100 && mode !== m; n++)
      @(posedge clk) #1;
    chk(16'(mode), 16'(m));
  endtask
  // Next pseudo-random value
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    {nrst, stuck, cerr, ovl, sev, fails, tests_run, cyc} = '0;
    sup = 1'b1;
    cen = 1'b1;
    r = 17'h1202E;
    @(posedge clk);
    #1 chk(16'(mode), 16'(hsw_pkg::M_OFF));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_mode(hsw_pkg::M_SLEEP);
    chk(16'(ch), 16'h0000);
    u_mcu.pins(4'h0, 1'b0, 1'b1);
    wait_mode(hsw_pkg::M_NORMAL);
    chk(16'(blank), 16'h0001);
    repeat (25) @(posedge clk);
    #1 chk(16'(idone), 16'h0001);
    u_mcu.wr(5'h02, 11'h100, 1'b0);
    @(posedge clk);
    #1 chk(16'({ows[0], ch[0]}), 16'h0003);
    for (int i = 0; i < 4; i++)
    begin
      r = lfsr(r);
      u_mcu.wr(5'h08, {5'h00, r[5:0]}, 1'b0);
      repeat (2) @(posedge clk);
      #1 chk(16'(ch), 16'(r[5:0]));
    end
    u_mcu.wr(5'h08, 11'h000, 1'b0);
    u_mcu.wr(5'h0B, 11'h001, 1'b0);
    u_mcu.pins(4'h1, 1'b0, 1'b1);
    repeat (5) @(posedge clk);
    #1 chk(16'(ch), 16'h0001);
    $display("normal mode tests done");
    u_mcu.pins(4'h5, 1'b1, 1'b1);
    wait_mode(hsw_pkg::M_FAIL);
    u_mcu.wr(5'h08, 11'h03F, 1'b0);
    repeat (4) @(posedge clk);
    #1 chk(16'({ocmax, diag, ch}), 16'h00C5);
    @(posedge clk);
    ovl <= 4'h1;
    repeat (5) @(posedge clk);
    #1 chk(16'(ch[0]), 16'h0000);
    ovl <= 4'h0;
    // Latch-off only arms once the wake blanking is over
    while (blank)
      @(posedge clk);
    @(posedge clk);
    sev <= 4'h4;
    repeat (5) @(posedge clk);
    sev <= 4'h0;
    repeat (5) @(posedge clk);
    #1 chk(16'(ch), 16'h0001);
    u_mcu.pins(4'h7, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(16'(ows), 16'h0002);
    $display("fail mode tests done");
    u_mcu.pins(4'h5, 1'b0, 1'b1);
    u_mcu.tog = 1'b0;
    repeat (4) @(posedge clk);
    u_mcu.wr(5'h00, 11'h000, 1'b0);
    u_mcu.wr(5'h00, 11'h000, 1'b0);
    wait_mode(hsw_pkg::M_NORMAL);
    u_mcu.rd(5'h11, v);
    chk(v, 16'h0600);
    u_mcu.rd(5'h11, v);
    chk(v, 16'h0400);
    u_mcu.wr(5'h02, 11'h100, 1'b0);
    u_mcu.wr(5'h02, 11'h100, 1'b1);
    wait_mode(hsw_pkg::M_FAIL);
    u_mcu.wr(5'h00, 11'h001, 1'b0);
    u_mcu.rd(5'h11, v);
    chk(v, 16'h0400);
    chk(16'(diag), 16'h0001);
    $display("recovery tests done");
    u_mcu.pins(4'h0, 1'b0, 1'b0);
    wait_mode(hsw_pkg::M_SLEEP);
    u_mcu.rd(5'h11, v);
    chk(v, 16'h0000);
    u_mcu.pins(4'h0, 1'b0, 1'b1);
    u_mcu.tog = 1'b0;
    wait_mode(hsw_pkg::M_NORMAL);
    u_mcu.rd(5'h11, v);
    chk(v, 16'h0000);
    @(posedge clk);
    cerr <= 1'b1;
    @(posedge clk);
    cerr <= 1'b0;
    wait_mode(hsw_pkg::M_FAIL);
    chk(16'(diag), 16'h0001);
    u_mcu.wr(5'h00, 11'h000, 1'b0);
    u_mcu.wr(5'h00, 11'h000, 1'b0);
    wait_mode(hsw_pkg::M_NORMAL);
    @(posedge clk);
    stuck <= 1'b1;
    @(posedge clk);
    stuck <= 1'b0;
    wait_mode(hsw_pkg::M_FAIL);
    chk(16'(diag), 16'h0000);
    @(posedge clk);
    {cen, sup} <= 2'b00;
    repeat (5) @(posedge clk);
    #1 chk(16'(mode), 16'(hsw_pkg::M_FAIL));
    @(posedge clk);
    cen <= 1'b1;
    wait_mode(hsw_pkg::M_OFF);
    chk(16'(ch), 16'h0000);
    $display("sleep and power-off tests done");
    stop_test();
  end
endmodule
`default_nettype wire
